/* hw/tcr_defs.svh */
`ifndef TCR_DEFS_SVH
`define TCR_DEFS_SVH

// Register byte addresses
`define TCR_ADDR_CTRL 8'h00
`define TCR_ADDR_CNT_LO 8'h04
`define TCR_ADDR_CNT_HI 8'h08
`define TCR_ADDR_CAP_LO 8'h0C
`define TCR_ADDR_CAP_HI 8'h10
`define TCR_ADDR_IRQ_STAT 8'h14
`define TCR_ADDR_IRQ_MASK 8'h18

// Control register fields
`define TCR_CTRL_OVF 7
`define TCR_CTRL_EXT 6
`define TCR_CTRL_RXSEL 5
`define TCR_CTRL_TXSEL 4
`define TCR_CTRL_EXTEN 3
`define TCR_CTRL_RUN 2
`define TCR_CTRL_CNTSEL 1
`define TCR_CTRL_CAPSEL 0

// Interrupt status fields
`define TCR_IRQ_OVF 0
`define TCR_IRQ_EXT 1

// Reset values
`define TCR_RST_BYTE 8'h00
`define TCR_RST_MASK 2'h0

// Machine cycle is twelve oscillator periods
`define TCR_OSC_DIV 12
`define TCR_DIV_LAST 4'hB

`endif

/* hw/tcr_pkg.sv */
package tcr_pkg;

    typedef enum logic [1:0] {
        TCR_MODE_OFF,
        TCR_MODE_RELOAD,
        TCR_MODE_CAPTURE,
        TCR_MODE_BAUD
    } tcr_mode_t;

endpackage

/* hw/tcr_fall_detect.sv */
`timescale 1ns/1ns

module tcr_fall_detect (
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic nrst_in,
    // Pin and sample strobe
    input wire logic pin_in,
    input wire logic sample_in,
    // One-cycle pulse per falling edge
    output logic fall_out
);

    logic meta_reg;
    logic sync_reg;
    logic prev_reg;
    logic fall_reg;
    logic fall_next;

    assign fall_next = sample_in && prev_reg && !sync_reg;
    assign fall_out = fall_reg;

    always_ff @(posedge sys_clk_in) begin
        if (!nrst_in) begin
            meta_reg <= 1'b1;
            sync_reg <= 1'b1;
            prev_reg <= 1'b1;
            fall_reg <= 1'b0;
        end else begin
            meta_reg <= pin_in;
            sync_reg <= meta_reg;
            if (sample_in) begin
                prev_reg <= sync_reg;
            end
            fall_reg <= fall_next;
        end
    end

endmodule

/* hw/tcr_timer.sv */
// The implementer's own choices: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ns
`include "tcr_defs.svh"

module tcr_timer (
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic nrst_in,
    // AHB-Lite slave
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic [31:0] hrdata_out,
    output logic hreadyout_out,
    output logic hresp_out,
    // Pins
    input wire logic count_input_in,
    input wire logic trigger_input_in,
    // Serial port clocking
    input wire logic timer1_ovf_in,
    input wire logic serial_var_mode_in,
    output logic rx_baud_clk_out,
    output logic tx_baud_clk_out,
    // Status
    output tcr_pkg::tcr_mode_t mode_out,
    output logic timer_irq_req_out,
    output logic irq_out
);
    import tcr_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    logic [7:0] ctrl_reg;
    logic [7:0] ctrl_next;
    logic [15:0] count_reg;
    logic [15:0] count_next;
    logic [15:0] cap_reg;
    logic [15:0] cap_next;
    logic [1:0] stat_reg;
    logic [1:0] stat_next;
    logic [1:0] mask_reg;
    logic [3:0] div_reg;
    logic mc_tick;
    logic count_fall;
    logic trig_fall;
    logic ovf_pulse_reg;

    ////////////////////////////////////////////////////////////////////////
    // Bus address and data phases
    logic ph_valid_reg;
    logic ph_write_reg;
    logic [7:0] ph_addr_reg;
    wire addr_take = hsel_in && htrans_in[1] && hready_in;
    wire wr_en = ph_valid_reg && ph_write_reg;
    wire wr_ctrl = wr_en && (ph_addr_reg == `TCR_ADDR_CTRL);
    wire wr_cnt_lo = wr_en && (ph_addr_reg == `TCR_ADDR_CNT_LO);
    wire wr_cnt_hi = wr_en && (ph_addr_reg == `TCR_ADDR_CNT_HI);
    wire wr_cap_lo = wr_en && (ph_addr_reg == `TCR_ADDR_CAP_LO);
    wire wr_cap_hi = wr_en && (ph_addr_reg == `TCR_ADDR_CAP_HI);
    wire wr_stat = wr_en && (ph_addr_reg == `TCR_ADDR_IRQ_STAT);
    wire wr_mask = wr_en && (ph_addr_reg == `TCR_ADDR_IRQ_MASK);
    wire [7:0] wbyte = hwdata_in[7:0];

    always_ff @(posedge sys_clk_in) begin
        if (!nrst_in) begin
            ph_valid_reg <= 1'b0;
            ph_write_reg <= 1'b0;
            ph_addr_reg <= 8'h00;
        end else if (hready_in) begin
            ph_valid_reg <= addr_take;
            ph_write_reg <= hwrite_in;
            ph_addr_reg <= haddr_in[7:0];
        end
    end

    assign hreadyout_out = 1'b1;
    assign hresp_out = 1'b0;

    // Read data taken from next-state values, so it matches the data phase
    logic [31:0] rdata_reg;
    wire [1:0] mask_next = wr_mask ? wbyte[1:0] : mask_reg;
    wire rd_take = addr_take && !hwrite_in;
    wire [7:0] rd_addr = haddr_in[7:0];
    wire [7:0] rd_byte =
        (rd_addr == `TCR_ADDR_CTRL) ? ctrl_next :
        (rd_addr == `TCR_ADDR_CNT_LO) ? count_next[7:0] :
        (rd_addr == `TCR_ADDR_CNT_HI) ? count_next[15:8] :
        (rd_addr == `TCR_ADDR_CAP_LO) ? cap_next[7:0] :
        (rd_addr == `TCR_ADDR_CAP_HI) ? cap_next[15:8] :
        (rd_addr == `TCR_ADDR_IRQ_STAT) ? {6'h00, stat_next} :
        (rd_addr == `TCR_ADDR_IRQ_MASK) ? {6'h00, mask_next} : 8'h00;

    always_ff @(posedge sys_clk_in) begin
        if (!nrst_in) begin
            rdata_reg <= 32'h00000000;
        end else if (hready_in) begin
            rdata_reg <= rd_take ? {24'h000000, rd_byte} : 32'h00000000;
        end
    end

    assign hrdata_out = rdata_reg;

    ////////////////////////////////////////////////////////////////////////
    // Machine-cycle strobe and pin edge detection
    assign mc_tick = (div_reg == `TCR_DIV_LAST);

    always_ff @(posedge sys_clk_in) begin
        if (!nrst_in) begin
            div_reg <= 4'h0;
        end else begin
            div_reg <= mc_tick ? 4'h0 : div_reg + 4'h1;
        end
    end

    tcr_fall_detect u_count_edge (
        .sys_clk_in(sys_clk_in),
        .nrst_in(nrst_in),
        .pin_in(count_input_in),
        .sample_in(mc_tick),
        .fall_out(count_fall)
    );

    tcr_fall_detect u_trig_edge (
        .sys_clk_in(sys_clk_in),
        .nrst_in(nrst_in),
        .pin_in(trigger_input_in),
        .sample_in(mc_tick),
        .fall_out(trig_fall)
    );

    ////////////////////////////////////////////////////////////////////////
    // Mode decode
    wire run = ctrl_reg[`TCR_CTRL_RUN];
    wire baud_sel = ctrl_reg[`TCR_CTRL_RXSEL] || ctrl_reg[`TCR_CTRL_TXSEL];
    wire ext_en = ctrl_reg[`TCR_CTRL_EXTEN];
    tcr_mode_t mode;

    always_comb begin
        if (!run) begin
            mode = TCR_MODE_OFF;
        end else if (baud_sel) begin
            mode = TCR_MODE_BAUD;
        end else if (ctrl_reg[`TCR_CTRL_CAPSEL]) begin
            mode = TCR_MODE_CAPTURE;
        end else begin
            mode = TCR_MODE_RELOAD;
        end
    end
    assign mode_out = mode;

    ////////////////////////////////////////////////////////////////////////
    // Counting, overflow, capture and reload
    wire cnt_tick = ctrl_reg[`TCR_CTRL_CNTSEL] ? count_fall : mc_tick;
    wire inc = run && cnt_tick;
    wire ovf = inc && (count_reg == 16'hFFFF);
    wire trig_ok = run && trig_fall && ext_en && !baud_sel;
    wire cap_evt = trig_ok && (mode == TCR_MODE_CAPTURE);
    wire trig_reload = trig_ok && (mode == TCR_MODE_RELOAD);
    wire ovf_reload = ovf && (mode != TCR_MODE_CAPTURE);
    wire ovf_flag_set = ovf && !baud_sel;
    wire ext_flag_set = cap_evt || trig_reload;

    always_comb begin
        count_next = count_reg;
        if (trig_reload || ovf_reload) begin
            count_next = cap_reg;
        end else if (inc) begin
            count_next = count_reg + 16'h0001;
        end
        if (wr_cnt_lo) begin
            count_next[7:0] = wbyte;
        end
        if (wr_cnt_hi) begin
            count_next[15:8] = wbyte;
        end
    end

    always_comb begin
        cap_next = cap_reg;
        if (cap_evt) begin
            cap_next = count_reg;
        end
        if (wr_cap_lo) begin
            cap_next[7:0] = wbyte;
        end
        if (wr_cap_hi) begin
            cap_next[15:8] = wbyte;
        end
    end

    // Flags hold until software writes 0; a new event wins over that clear
    always_comb begin
        ctrl_next = wr_ctrl ? wbyte : ctrl_reg;
        if (ovf_flag_set) begin
            ctrl_next[`TCR_CTRL_OVF] = 1'b1;
        end
        if (ext_flag_set) begin
            ctrl_next[`TCR_CTRL_EXT] = 1'b1;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!nrst_in) begin
            ctrl_reg <= `TCR_RST_BYTE;
            count_reg <= {`TCR_RST_BYTE, `TCR_RST_BYTE};
            cap_reg <= {`TCR_RST_BYTE, `TCR_RST_BYTE};
            ovf_pulse_reg <= 1'b0;
        end else begin
            ctrl_reg <= ctrl_next;
            count_reg <= count_next;
            cap_reg <= cap_next;
            ovf_pulse_reg <= ovf;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Serial port clock selection
    wire rx_src = ctrl_reg[`TCR_CTRL_RXSEL] ? ovf_pulse_reg : timer1_ovf_in;
    wire tx_src = ctrl_reg[`TCR_CTRL_TXSEL] ? ovf_pulse_reg : timer1_ovf_in;
    assign rx_baud_clk_out = serial_var_mode_in && rx_src;
    assign tx_baud_clk_out = serial_var_mode_in && tx_src;

    ////////////////////////////////////////////////////////////////////////
    // Interrupts
    assign timer_irq_req_out = ctrl_reg[`TCR_CTRL_OVF] || ctrl_reg[`TCR_CTRL_EXT];

    always_comb begin
        stat_next = stat_reg;
        if (wr_stat) begin
            stat_next = stat_reg & ~wbyte[1:0];
        end
        if (ovf_flag_set) begin
            stat_next[`TCR_IRQ_OVF] = 1'b1;
        end
        if (ext_flag_set) begin
            stat_next[`TCR_IRQ_EXT] = 1'b1;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!nrst_in) begin
            stat_reg <= `TCR_RST_MASK;
            mask_reg <= `TCR_RST_MASK;
        end else begin
            stat_reg <= stat_next;
            if (wr_mask) begin
                mask_reg <= wbyte[1:0];
            end
        end
    end

    assign irq_out = |(stat_reg & mask_reg);

    ////////////////////////////////////////////////////////////////////////
    // Checks
    property p_ovf_flag;
        @(posedge sys_clk_in) disable iff (!nrst_in)
        (ovf && !baud_sel) |=> ctrl_reg[`TCR_CTRL_OVF] && stat_reg[`TCR_IRQ_OVF];
    endproperty
    a_ovf_flag: assert property (p_ovf_flag) else $error("overflow flag not set");

    property p_baud_noflag;
        @(posedge sys_clk_in) disable iff (!nrst_in)
        (baud_sel && !ctrl_reg[`TCR_CTRL_OVF] && !wr_ctrl) |=> !ctrl_reg[`TCR_CTRL_OVF];
    endproperty
    a_baud_noflag: assert property (p_baud_noflag) else $error("flag set in baud mode");

    property p_reload;
        @(posedge sys_clk_in) disable iff (!nrst_in)
        (ovf && mode != TCR_MODE_CAPTURE && !wr_cnt_lo && !wr_cnt_hi)
        |=> count_reg == $past(cap_reg);
    endproperty
    a_reload: assert property (p_reload) else $error("rollover did not reload");

    property p_capture;
        @(posedge sys_clk_in) disable iff (!nrst_in)
        (cap_evt && !wr_cap_lo && !wr_cap_hi)
        |=> cap_reg == $past(count_reg) && ctrl_reg[`TCR_CTRL_EXT];
    endproperty
    a_capture: assert property (p_capture) else $error("capture missed");

    property p_trig_reload;
        @(posedge sys_clk_in) disable iff (!nrst_in)
        (trig_reload && !wr_cnt_lo && !wr_cnt_hi) |=> count_reg == $past(cap_reg);
    endproperty
    a_trig_reload: assert property (p_trig_reload) else $error("trigger reload missed");

    property p_trig_ignored;
        @(posedge sys_clk_in) disable iff (!nrst_in)
        (trig_fall && (!ext_en || baud_sel) && !wr_ctrl && !ctrl_reg[`TCR_CTRL_EXT])
        |=> !ctrl_reg[`TCR_CTRL_EXT];
    endproperty
    a_trig_ignored: assert property (p_trig_ignored) else $error("trigger not ignored");

    property p_stopped;
        @(posedge sys_clk_in) disable iff (!nrst_in)
        (!run && !wr_en) |=> count_reg == $past(count_reg) && cap_reg == $past(cap_reg);
    endproperty
    a_stopped: assert property (p_stopped) else $error("stopped timer changed");

    property p_irq;
        @(posedge sys_clk_in) disable iff (!nrst_in)
        (ovf_flag_set && mask_reg[`TCR_IRQ_OVF]) |=> irq_out && timer_irq_req_out;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt not raised");

    property p_rx_clk;
        @(posedge sys_clk_in) disable iff (!nrst_in)
        (ovf && ctrl_reg[`TCR_CTRL_RXSEL] && serial_var_mode_in) |=>
        (ctrl_reg[`TCR_CTRL_RXSEL] && serial_var_mode_in) |-> rx_baud_clk_out;
    endproperty
    a_rx_clk: assert property (p_rx_clk) else $error("receive clock missed");

    property p_tx_clk;
        @(posedge sys_clk_in) disable iff (!nrst_in)
        (!ctrl_reg[`TCR_CTRL_TXSEL] && serial_var_mode_in)
        |-> tx_baud_clk_out == timer1_ovf_in;
    endproperty
    a_tx_clk: assert property (p_tx_clk) else $error("transmit clock wrong");

    property p_tick_rate;
        @(posedge sys_clk_in) disable iff (!nrst_in)
        mc_tick |=> !mc_tick [*8] ##1 !mc_tick ##1 !mc_tick ##1 !mc_tick ##1 mc_tick;
    endproperty
    a_tick_rate: assert property (p_tick_rate) else $error("machine cycle not twelve");

endmodule

/* verification/tcr_serial_partner.sv */
`timescale 1ns/1ns

module tcr_serial_partner (
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic nrst_in,
    // Serial port clocks from the timer
    input wire logic rx_baud_clk_in,
    input wire logic tx_baud_clk_in,
    // Timer one overflow source
    output logic timer1_ovf_out,
    // Pulse tallies
    output logic [15:0] rx_cnt_out,
    output logic [15:0] tx_cnt_out,
    output logic [15:0] t1_cnt_out
);
    logic [2:0] div_reg;
    logic div_wrap;

    // Timer one overflows every seven clocks, one cycle wide
    assign div_wrap = (div_reg == 3'h6);

    always_ff @(posedge sys_clk_in) begin
        if (!nrst_in) begin
            div_reg <= 3'h0;
            timer1_ovf_out <= 1'b0;
            rx_cnt_out <= 16'h0000;
            tx_cnt_out <= 16'h0000;
            t1_cnt_out <= 16'h0000;
        end else begin
            div_reg <= div_wrap ? 3'h0 : div_reg + 3'h1;
            timer1_ovf_out <= div_wrap;
            rx_cnt_out <= rx_cnt_out + {15'h0000, rx_baud_clk_in};
            tx_cnt_out <= tx_cnt_out + {15'h0000, tx_baud_clk_in};
            t1_cnt_out <= t1_cnt_out + {15'h0000, timer1_ovf_out};
        end
    end
endmodule

/* verification/tb_top.sv */
`timescale 1ns/1ns
`include "tcr_defs.svh"

module tb_top;
    import tcr_pkg::*;
    logic sys_clk_in, nrst_in, hsel, hwrite, hready, hresp, cnt_pin, trig_pin;
    logic t1_ovf, ser_mode, rx_clk, tx_clk, irq_req, irq;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [15:0] rx_cnt, tx_cnt, t1_cnt, rx0, tx0, t10;
    logic [7:0] addrs [8];
    tcr_mode_t mode;
    int error_cnt, cmp_count;

    tcr_timer i_tcr_timer (.sys_clk_in(sys_clk_in), .nrst_in(nrst_in), .hsel_in(hsel),
        .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2),
        .hwdata_in(hwdata), .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready),
        .hresp_out(hresp), .count_input_in(cnt_pin), .trigger_input_in(trig_pin),
        .timer1_ovf_in(t1_ovf), .serial_var_mode_in(ser_mode), .rx_baud_clk_out(rx_clk),
        .tx_baud_clk_out(tx_clk), .mode_out(mode), .timer_irq_req_out(irq_req),
        .irq_out(irq));

    tcr_serial_partner i_tcr_serial_partner (.sys_clk_in(sys_clk_in), .nrst_in(nrst_in),
        .rx_baud_clk_in(rx_clk), .tx_baud_clk_in(tx_clk), .timer1_ovf_out(t1_ovf),
        .rx_cnt_out(rx_cnt), .tx_cnt_out(tx_cnt), .t1_cnt_out(t1_cnt));

    initial begin
        sys_clk_in = 1'b0;
        forever #20 sys_clk_in = ~sys_clk_in;
    end

    task automatic complete_run();
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic clocks(input int n);
        repeat (n) @(posedge sys_clk_in);
    endtask

    task automatic wait_ready();
        int n;
        n = 0;
        @(posedge sys_clk_in);
        while (hready !== 1'b1 && n < 50) begin
            @(posedge sys_clk_in);
            n++;
        end
        if (hready !== 1'b1) begin
            chk("hready wait", {31'h00000000, hready}, 32'h00000001);
            complete_run();
        end
    endtask

    // Single AHB transfer; read data lands in rd
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge sys_clk_in);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        htrans <= 2'h2;
        hwrite <= w;
        wait_ready();
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        wait_ready();
        rd = hrdata;
    endtask

    task automatic rchk(input string name, input logic [7:0] a, input logic [31:0] e);
        bus(a, 1'b0, 32'h00000000);
        chk(name, rd, e);
    endtask

    // One falling then rising edge, each level held beyond a machine cycle
    task automatic fall(input logic on_trig);
        if (on_trig) begin
            trig_pin <= 1'b0;
        end else begin
            cnt_pin <= 1'b0;
        end
        clocks(30);
        if (on_trig) begin
            trig_pin <= 1'b1;
        end else begin
            cnt_pin <= 1'b1;
        end
        clocks(30);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        error_cnt = 0;
        cmp_count = 0;
        nrst_in = 1'b0;
        hsel = 1'b0;
        haddr = 32'h00000000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hwdata = 32'h00000000;
        cnt_pin = 1'b1;
        trig_pin = 1'b1;
        ser_mode = 1'b0;
        addrs = '{`TCR_ADDR_CTRL, `TCR_ADDR_CNT_LO, `TCR_ADDR_CNT_HI, `TCR_ADDR_CAP_LO,
            `TCR_ADDR_CAP_HI, `TCR_ADDR_IRQ_STAT, `TCR_ADDR_IRQ_MASK, 8'h1C};
        clocks(16);
        nrst_in <= 1'b1;
        clocks(1);
        bus(8'h1C, 1'b1, 32'h000000FF);
        for (int i = 0; i < 8; i++) begin
            rchk("reset value", addrs[i], 32'h00000000);
        end
        chk("mode off", {30'h00000000, mode}, {30'h00000000, TCR_MODE_OFF});
        chk("hresp okay", {31'h00000000, hresp}, 32'h00000000);
        // Auto-reload on rollover
        bus(`TCR_ADDR_CAP_LO, 1'b1, 32'h00000034);
        bus(`TCR_ADDR_CAP_HI, 1'b1, 32'h00000012);
        bus(`TCR_ADDR_CNT_LO, 1'b1, 32'h000000FE);
        bus(`TCR_ADDR_CNT_HI, 1'b1, 32'h000000FF);
        bus(`TCR_ADDR_CTRL, 1'b1, 32'h00000004);
        clocks(1);
        chk("mode reload", {30'h00000000, mode}, {30'h00000000, TCR_MODE_RELOAD});
        clocks(40);
        rchk("ctrl ovf", `TCR_ADDR_CTRL, 32'h00000084);
        rchk("reload hi", `TCR_ADDR_CNT_HI, 32'h00000012);
        chk("irq req", {31'h00000000, irq_req}, 32'h00000001);
        rchk("irq stat", `TCR_ADDR_IRQ_STAT, 32'h00000001);
        chk("irq masked", {31'h00000000, irq}, 32'h00000000);
        bus(`TCR_ADDR_IRQ_MASK, 1'b1, 32'h00000003);
        clocks(1);
        chk("irq unmasked", {31'h00000000, irq}, 32'h00000001);
        bus(`TCR_ADDR_IRQ_STAT, 1'b1, 32'h00000001);
        rchk("irq stat clr", `TCR_ADDR_IRQ_STAT, 32'h00000000);
        chk("irq cleared", {31'h00000000, irq}, 32'h00000000);
        // Stopped: values hold, writes accepted
        bus(`TCR_ADDR_CTRL, 1'b1, 32'h00000080);
        bus(`TCR_ADDR_CNT_LO, 1'b1, 32'h00000055);
        clocks(40);
        rchk("stopped count", `TCR_ADDR_CNT_LO, 32'h00000055);
        rchk("flag kept", `TCR_ADDR_CTRL, 32'h00000080);
        bus(`TCR_ADDR_CTRL, 1'b1, 32'h00000000);
        clocks(1);
        chk("irq req clr", {31'h00000000, irq_req}, 32'h00000000);
        // Capture with and without external enable
        bus(`TCR_ADDR_CNT_HI, 1'b1, 32'h000000AB);
        bus(`TCR_ADDR_CNT_LO, 1'b1, 32'h00000000);
        bus(`TCR_ADDR_CTRL, 1'b1, 32'h00000005);
        clocks(1);
        chk("mode capture", {30'h00000000, mode}, {30'h00000000, TCR_MODE_CAPTURE});
        fall(1'b1);
        rchk("no capture", `TCR_ADDR_CAP_HI, 32'h00000012);
        rchk("no ext flag", `TCR_ADDR_CTRL, 32'h00000005);
        bus(`TCR_ADDR_CTRL, 1'b1, 32'h0000000D);
        fall(1'b1);
        rchk("captured hi", `TCR_ADDR_CAP_HI, 32'h000000AB);
        clocks(40);
        rchk("ext flag held", `TCR_ADDR_CTRL, 32'h0000004D);
        // Trigger forces reload
        bus(`TCR_ADDR_CTRL, 1'b1, 32'h0000000C);
        bus(`TCR_ADDR_CNT_HI, 1'b1, 32'h00000000);
        fall(1'b1);
        rchk("forced reload", `TCR_ADDR_CNT_HI, 32'h000000AB);
        rchk("reload ext flag", `TCR_ADDR_CTRL, 32'h0000004C);
        // Capture-mode overflow wraps to zero
        bus(`TCR_ADDR_CTRL, 1'b1, 32'h00000000);
        bus(`TCR_ADDR_CNT_LO, 1'b1, 32'h000000FF);
        bus(`TCR_ADDR_CNT_HI, 1'b1, 32'h000000FF);
        bus(`TCR_ADDR_CTRL, 1'b1, 32'h00000005);
        clocks(30);
        rchk("wrap flag", `TCR_ADDR_CTRL, 32'h00000085);
        rchk("wrap hi", `TCR_ADDR_CNT_HI, 32'h00000000);
        // Event counter on count-pin falls
        bus(`TCR_ADDR_CTRL, 1'b1, 32'h00000000);
        bus(`TCR_ADDR_CNT_LO, 1'b1, 32'h00000000);
        bus(`TCR_ADDR_CNT_HI, 1'b1, 32'h00000000);
        bus(`TCR_ADDR_CTRL, 1'b1, 32'h00000006);
        for (int i = 0; i < 5; i++) begin
            fall(1'b0);
        end
        rchk("event count", `TCR_ADDR_CNT_LO, 32'h00000005);
        // Baud generation, receive then transmit select
        bus(`TCR_ADDR_CTRL, 1'b1, 32'h00000000);
        bus(`TCR_ADDR_CNT_LO, 1'b1, 32'h000000FF);
        bus(`TCR_ADDR_CNT_HI, 1'b1, 32'h000000FF);
        bus(`TCR_ADDR_CAP_LO, 1'b1, 32'h000000FE);
        bus(`TCR_ADDR_CAP_HI, 1'b1, 32'h000000FF);
        ser_mode <= 1'b1;
        for (int i = 0; i < 2; i++) begin
            bus(`TCR_ADDR_CTRL, 1'b1, (i == 0) ? 32'h0000002D : 32'h0000001D);
            clocks(1);
            chk("mode baud", {30'h00000000, mode}, {30'h00000000, TCR_MODE_BAUD});
            rx0 = rx_cnt;
            tx0 = tx_cnt;
            t10 = t1_cnt;
            fall(1'b1);
            clocks(180);
            rx0 = rx_cnt - rx0;
            tx0 = tx_cnt - tx0;
            t10 = t1_cnt - t10;
            if (i == 0) begin
                chk("rx from t2", {31'h00000000, rx0 >= 9 && rx0 <= 11}, 32'h00000001);
                chk("tx from t1", {16'h0000, tx0}, {16'h0000, t10});
            end else begin
                chk("tx from t2", {31'h00000000, tx0 >= 9 && tx0 <= 11}, 32'h00000001);
                chk("rx from t1", {16'h0000, rx0}, {16'h0000, t10});
            end
            rchk("baud flags", `TCR_ADDR_CTRL, (i == 0) ? 32'h0000002D : 32'h0000001D);
            rchk("baud reload", `TCR_ADDR_CNT_HI, 32'h000000FF);
        end
        complete_run();
    end
endmodule
